// *** inc/sysopt_pkg.sv ***
// constants, field positions and carrier types for the system option register bank
// assumes one 8-bit register port shared by user program and serial debug writes
`default_nettype none
package sysopt_pkg;
  // register select codes on the register port
  localparam logic [2:0] ADDR_DBG_FORCE = 3'h0;
  localparam logic [2:0] ADDR_OPT_ONE = 3'h1;
  localparam logic [2:0] ADDR_OPT_TWO = 3'h2;
  localparam logic [2:0] ADDR_RST_STATUS = 3'h3;
  // option register one field positions
  localparam int OPT1_TMO_HI = 7;
  localparam int OPT1_TMO_LO = 6;
  localparam int OPT1_STOP = 5;
  localparam int OPT1_I2C = 2;
  // option register two field positions
  localparam int OPT2_WCLK = 7;
  localparam int OPT2_WIN = 6;
  localparam int OPT2_CMP = 4;
  localparam int OPT2_T2C1 = 3;
  localparam int OPT2_T2C0 = 2;
  localparam int OPT2_T1C1 = 1;
  localparam int OPT2_T1C0 = 0;
  localparam int FORCE_BIT = 0;
  // values after reset and implemented-bit masks
  localparam logic [7:0] OPT1_RST = 8'hC0;
  localparam logic [7:0] OPT2_RST = 8'h00;
  localparam logic [7:0] OPT1_MASK = 8'hE4;
  localparam logic [7:0] OPT2_MASK = 8'hDF;
  localparam logic [7:0] OPT2_ONCE_MASK = 8'hC0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // watchdog refresh key pair
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] TMO_OFF = 2'h0;

  // one register port request, valid for one cycle
  typedef struct packed {
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic from_dbg;
  } bus_req_t;

  // decoded option settings driven to the rest of the chip
  typedef struct packed {
    logic [1:0] watchdog_timeout_sel;
    logic watchdog_clock_sel;
    logic watchdog_window_mode;
    logic stop_mode_allow;
    logic i2c_pin_route;
    logic comparator_to_capture;
    logic timer2_ch1_route;
    logic timer2_ch0_route;
    logic timer1_ch1_route;
    logic timer1_ch0_route;
  } opt_out_t;

  // whole state of the bank
  typedef struct packed {
    logic [7:0] opt_one;
    logic [7:0] opt_two;
    logic lock_one;
    logic lock_two;
    logic key_armed;
    logic [7:0] rd_data;
    logic force_rst;
    logic stop_rst;
    logic stop_enter;
    logic wdog_refresh;
    logic wdog_rst;
    logic cmp_s1;
    logic cmp_s2;
    logic pin_s1;
    logic pin_s2;
    logic ch0_in;
    opt_out_t opts;
  } state_t;
endpackage
`default_nettype wire

// *** src/system_option_control_regs.sv ***
// system option register bank: debug force reset, write-once options, pin routing
// assumes register port and stop/window strobes come from logic on clk_sys_i
// assumes the system reset logic turns each reset pulse into a full sys_rst_i
`default_nettype none
module system_option_control_regs
  import sysopt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire bus_req_t bus_req_i,
  input wire logic stop_exec_i,
  input wire logic wdog_window_open_i,
  input wire logic cmp_out_i,
  input wire logic timer_module_one_ch0_pin_i,
  output logic [7:0] rd_data_o,
  output opt_out_t opts_o,
  output logic dbg_force_reset_o,
  output logic illegal_stop_reset_o,
  output logic stop_enter_o,
  output logic wdog_refresh_o,
  output logic wdog_reset_o,
  output logic timer_module_one_ch0_in_o
);

  // registered state and its next value
  state_t state_ff;
  state_t nxt_state;

  // decoded write strobes
  logic wr_force;
  logic wr_one;
  logic wr_two;
  logic wr_status;
  // watchdog is running when a timeout is selected
  logic wdog_on;
  // window mode in force only with bus clock source
  logic window_eff;

  // address decode of the register port
  always_comb begin
    wr_force = bus_req_i.wr && (bus_req_i.addr == ADDR_DBG_FORCE);
    wr_one = bus_req_i.wr && (bus_req_i.addr == ADDR_OPT_ONE);
    wr_two = bus_req_i.wr && (bus_req_i.addr == ADDR_OPT_TWO);
    wr_status = bus_req_i.wr && (bus_req_i.addr == ADDR_RST_STATUS);
    wdog_on = state_ff.opt_one[OPT1_TMO_HI:OPT1_TMO_LO] != TMO_OFF;
    window_eff = state_ff.opt_two[OPT2_WIN] && state_ff.opt_two[OPT2_WCLK];
  end

  // next-state logic for the whole bank
  always_comb begin
    nxt_state = state_ff;
    // one-cycle pulses default low
    nxt_state.force_rst = 1'b0;
    nxt_state.stop_rst = 1'b0;
    nxt_state.stop_enter = 1'b0;
    nxt_state.wdog_refresh = 1'b0;
    nxt_state.wdog_rst = 1'b0;

    if (wr_force && bus_req_i.from_dbg) begin
      nxt_state.force_rst = bus_req_i.wdata[FORCE_BIT];
    end

    if (wr_one && !state_ff.lock_one) begin
      nxt_state.opt_one = bus_req_i.wdata & OPT1_MASK;
      nxt_state.lock_one = 1'b1;
    end

    // option two: once-bits lock, routing bits stay writable
    if (wr_two) begin
      if (state_ff.lock_two) begin
        nxt_state.opt_two = (state_ff.opt_two & OPT2_ONCE_MASK)
                          | (bus_req_i.wdata & OPT2_MASK & ~OPT2_ONCE_MASK);
      end else begin
        nxt_state.opt_two = bus_req_i.wdata & OPT2_MASK;
        nxt_state.lock_two = 1'b1;
      end
    end

    if (stop_exec_i) begin
      if (state_ff.opts.stop_mode_allow) begin
        nxt_state.stop_enter = 1'b1;
      end else begin
        nxt_state.stop_rst = 1'b1;
      end
    end

    // watchdog key sequence on the reset status address
    if (wr_status) begin
      if (window_eff && !wdog_window_open_i) begin
        nxt_state.wdog_rst = wdog_on;
        nxt_state.key_armed = 1'b0;
      end else if (bus_req_i.wdata == KEY_FIRST) begin
        // first key arms the sequence
        nxt_state.key_armed = 1'b1;
      end else if (bus_req_i.wdata == KEY_SECOND) begin
        nxt_state.wdog_refresh = state_ff.key_armed;
        nxt_state.key_armed = 1'b0;
      end else begin
        nxt_state.wdog_rst = wdog_on;
        nxt_state.key_armed = 1'b0;
      end
    end

    // register read data, only sampled on a read
    if (bus_req_i.rd) begin
      unique case (bus_req_i.addr)
        ADDR_DBG_FORCE: nxt_state.rd_data = READ_ZERO;
        ADDR_OPT_ONE: nxt_state.rd_data = state_ff.opt_one;
        ADDR_OPT_TWO: nxt_state.rd_data = state_ff.opt_two;
        // status and unmapped codes read zero here
        default: nxt_state.rd_data = READ_ZERO;
      endcase
    end

    // two-flop synchronisers for pin-side inputs
    nxt_state.cmp_s1 = cmp_out_i;
    nxt_state.cmp_s2 = state_ff.cmp_s1;
    nxt_state.pin_s1 = timer_module_one_ch0_pin_i;
    nxt_state.pin_s2 = state_ff.pin_s1;
    nxt_state.ch0_in = state_ff.opts.comparator_to_capture ? state_ff.cmp_s2
                                                          : state_ff.pin_s2;

    // decoded settings follow the next register values
    // timeout select out
    nxt_state.opts.watchdog_timeout_sel = nxt_state.opt_one[OPT1_TMO_HI:OPT1_TMO_LO];
    nxt_state.opts.stop_mode_allow = nxt_state.opt_one[OPT1_STOP];
    nxt_state.opts.i2c_pin_route = nxt_state.opt_one[OPT1_I2C];
    nxt_state.opts.watchdog_clock_sel = nxt_state.opt_two[OPT2_WCLK];
    nxt_state.opts.watchdog_window_mode = nxt_state.opt_two[OPT2_WIN]
                                        && nxt_state.opt_two[OPT2_WCLK];
    nxt_state.opts.comparator_to_capture = nxt_state.opt_two[OPT2_CMP];
    nxt_state.opts.timer2_ch1_route = nxt_state.opt_two[OPT2_T2C1];
    nxt_state.opts.timer2_ch0_route = nxt_state.opt_two[OPT2_T2C0];
    nxt_state.opts.timer1_ch1_route = nxt_state.opt_two[OPT2_T1C1];
    nxt_state.opts.timer1_ch0_route = nxt_state.opt_two[OPT2_T1C0];
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= '0;
      state_ff.opt_one <= OPT1_RST;
      state_ff.opt_two <= OPT2_RST;
      state_ff.opts.watchdog_timeout_sel <= OPT1_RST[OPT1_TMO_HI:OPT1_TMO_LO];
      state_ff.opts.stop_mode_allow <= OPT1_RST[OPT1_STOP];
      state_ff.opts.i2c_pin_route <= OPT1_RST[OPT1_I2C];
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign rd_data_o = state_ff.rd_data;
  assign opts_o = state_ff.opts;
  assign dbg_force_reset_o = state_ff.force_rst;
  assign illegal_stop_reset_o = state_ff.stop_rst;
  assign stop_enter_o = state_ff.stop_enter;
  assign wdog_refresh_o = state_ff.wdog_refresh;
  assign wdog_reset_o = state_ff.wdog_rst;
  assign timer_module_one_ch0_in_o = state_ff.ch0_in;

  // checks on the bank behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // key pair written back to back
  sequence s_key_first;
    wr_status && (bus_req_i.wdata == KEY_FIRST) && (!window_eff || wdog_window_open_i);
  endsequence
  sequence s_key_second;
    wr_status && (bus_req_i.wdata == KEY_SECOND) && (!window_eff || wdog_window_open_i);
  endsequence

  a_force_reads_zero: assert property (
    bus_req_i.rd && (bus_req_i.addr == ADDR_DBG_FORCE) |=> rd_data_o == READ_ZERO)
    else $error("force reset register read not zero");

  a_user_force_ignored: assert property (
    wr_force && !bus_req_i.from_dbg |=> !dbg_force_reset_o)
    else $error("user write forced a reset");

  a_dbg_force_pulse: assert property (
    wr_force && bus_req_i.from_dbg && bus_req_i.wdata[FORCE_BIT] && !$past(wr_force)
    |=> dbg_force_reset_o ##1 !dbg_force_reset_o)
    else $error("debug force reset pulse wrong");

  a_opt_one_locked: assert property (
    state_ff.lock_one && wr_one |=> $stable(state_ff.opt_one))
    else $error("option one changed after lock");

  a_opt_one_first: assert property (
    !state_ff.lock_one && wr_one
    |=> opts_o.watchdog_timeout_sel == $past(bus_req_i.wdata[OPT1_TMO_HI:OPT1_TMO_LO]))
    else $error("timeout field not taken on first write");

  a_stop_illegal: assert property (
    stop_exec_i && !opts_o.stop_mode_allow |=> illegal_stop_reset_o && !stop_enter_o)
    else $error("disallowed stop did not reset");

  a_i2c_route: assert property (
    !state_ff.lock_one && wr_one |=> opts_o.i2c_pin_route == $past(bus_req_i.wdata[OPT1_I2C]))
    else $error("i2c routing not taken");

  a_window_early: assert property (
    wr_status && window_eff && !wdog_window_open_i && wdog_on |=> wdog_reset_o)
    else $error("early refresh write did not reset");

  a_window_gated: assert property (
    opts_o.watchdog_window_mode |-> opts_o.watchdog_clock_sel)
    else $error("window mode without bus clock");

  a_opt_two_once: assert property (
    state_ff.lock_two && wr_two |=> $stable(state_ff.opt_two[OPT2_WCLK:OPT2_WIN]))
    else $error("option two once-bits changed");

  a_key_refresh: assert property (
    s_key_first ##1 s_key_second |=> wdog_refresh_o && !wdog_reset_o)
    else $error("key pair did not refresh watchdog");

  a_reset_defaults: assert property (
    $past(sys_rst_i) |-> !state_ff.lock_one && !state_ff.lock_two
                       && (state_ff.opt_two == OPT2_RST))
    else $error("reset left locks or routing set");

  // timer two ch1 routing follows every option two write
  a_route_t2c1: assert property (
    wr_two |=> opts_o.timer2_ch1_route == $past(bus_req_i.wdata[OPT2_T2C1]))
    else $error("timer two ch1 routing not taken");

  // timer two ch0 routing follows every option two write
  a_route_t2c0: assert property (
    wr_two |=> opts_o.timer2_ch0_route == $past(bus_req_i.wdata[OPT2_T2C0]))
    else $error("timer two ch0 routing not taken");

  // timer one ch1 routing follows every option two write
  a_route_t1c1: assert property (
    wr_two |=> opts_o.timer1_ch1_route == $past(bus_req_i.wdata[OPT2_T1C1]))
    else $error("timer one ch1 routing not taken");

  // timer one ch0 routing follows every option two write
  a_route_t1c0: assert property (
    wr_two |=> opts_o.timer1_ch0_route == $past(bus_req_i.wdata[OPT2_T1C0]))
    else $error("timer one ch0 routing not taken");

  // comparator link bit stays writable after the lock
  a_cmp_link_bit: assert property (
    wr_two |=> opts_o.comparator_to_capture == $past(bus_req_i.wdata[OPT2_CMP]))
    else $error("comparator link bit not taken");

  // watchdog clock source taken on the first write
  a_wclk_first: assert property (
    !state_ff.lock_two && wr_two
    |=> opts_o.watchdog_clock_sel == $past(bus_req_i.wdata[OPT2_WCLK]))
    else $error("watchdog clock select not taken");

  // first option two write lands on every implemented bit
  a_opt_two_first: assert property (
    !state_ff.lock_two && wr_two
    |=> state_ff.opt_two == ($past(bus_req_i.wdata) & OPT2_MASK))
    else $error("first option two write not taken");

  // allowed stop enters stop mode without a reset
  a_stop_allowed: assert property (
    stop_exec_i && opts_o.stop_mode_allow |=> stop_enter_o && !illegal_stop_reset_o)
    else $error("allowed stop did not enter stop");

  // any value but the two keys resets a running watchdog
  sequence s_key_wrong;
    wr_status && wdog_on && (bus_req_i.wdata != KEY_FIRST) && (bus_req_i.wdata != KEY_SECOND);
  endsequence
  a_key_wrong_reset: assert property (
    s_key_wrong |=> wdog_reset_o)
    else $error("wrong key did not reset watchdog");

  // second key without the first gives no refresh
  a_lone_second: assert property (
    wr_status && (bus_req_i.wdata == KEY_SECOND) && !state_ff.key_armed |=> !wdog_refresh_o)
    else $error("lone second key refreshed watchdog");

  // debug write of zero forces nothing
  a_force_zero: assert property (
    wr_force && bus_req_i.from_dbg && !bus_req_i.wdata[FORCE_BIT] |=> !dbg_force_reset_o)
    else $error("debug zero write forced a reset");

  // force request lasts a single cycle
  a_force_once: assert property (
    dbg_force_reset_o && !wr_force |=> !dbg_force_reset_o)
    else $error("force reset request held too long");

  // normal mode takes a first key at any time
  a_window_normal: assert property (
    wr_status && !window_eff && (bus_req_i.wdata == KEY_FIRST)
    |=> !wdog_reset_o)
    else $error("normal mode key caused a reset");

endmodule // system_option_control_regs
`default_nettype wire

// *** tb/debug_host_model.sv ***
// serial debug host model: turns a command strobe into a debug write request
// assumes the bench ORs its request with the user program request
`default_nettype none
module debug_host_model
  import sysopt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic go_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output var bus_req_t req_o
);
  // one write-byte command, held for as many cycles as go_i is high
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !go_i) begin
      req_o <= '0;
    end else begin
      req_o <= '{addr: addr_i, wr: 1'b1, rd: 1'b0, wdata: data_i, from_dbg: 1'b1};
    end
  end
endmodule // debug_host_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the system option register bank
// assumes debug host model in its own file, one 100 MHz clock
`default_nettype none
module testbench
  import sysopt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, sys_rst_i, stop_exec_i, wdog_window_open_i, cmp_out_i, timer_module_one_ch0_pin_i;
  logic dbg_go;
  logic [2:0] dbg_addr;
  logic [7:0] dbg_data, rd_data;
  bus_req_t cpu_req, dbg_req, bus_req;
  opt_out_t opts;
  logic frc, ill, stp, rfr, wrst, ch0;
  int mismatches, total_checks;
  // both requesters share the port, never at once
  assign bus_req = cpu_req | dbg_req;
  debug_host_model host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .go_i(dbg_go),
    .addr_i(dbg_addr), .data_i(dbg_data), .req_o(dbg_req));
  system_option_control_regs dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .bus_req_i(bus_req), .stop_exec_i(stop_exec_i), .wdog_window_open_i(wdog_window_open_i),
    .cmp_out_i(cmp_out_i), .timer_module_one_ch0_pin_i(timer_module_one_ch0_pin_i), .rd_data_o(rd_data),
    .opts_o(opts), .dbg_force_reset_o(frc), .illegal_stop_reset_o(ill),
    .stop_enter_o(stp), .wdog_refresh_o(rfr), .wdog_reset_o(wrst), .timer_module_one_ch0_in_o(ch0));
  // clock generator
  initial clk_sys_i = 1'b0;
  always #5 clk_sys_i = ~clk_sys_i;
  // compare and count
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // user program access, outputs settled on return
  task cpu(input logic [2:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys_i);
    cpu_req <= '{addr: a, wr: w, rd: !w, wdata: d, from_dbg: 1'b0};
    @(posedge clk_sys_i);
    cpu_req <= '0;
    #1;
  endtask
  // debug host write through the model
  task dbg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    dbg_go <= 1'b1;
    dbg_addr <= a;
    dbg_data <= d;
    @(posedge clk_sys_i);
    dbg_go <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  // key pair on consecutive cycles
  task key_pair;
    @(posedge clk_sys_i);
    cpu_req <= '{addr: ADDR_RST_STATUS, wr: 1'b1, rd: 1'b0, wdata: KEY_FIRST, from_dbg: 1'b0};
    @(posedge clk_sys_i);
    cpu_req.wdata <= KEY_SECOND;
    @(posedge clk_sys_i);
    cpu_req <= '0;
    #1;
  endtask
  task rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    cpu(a, 1'b0, 8'h00);
    chk(what, exp, rd_data);
  endtask
  task do_reset;
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // one stop instruction, pulses settled on return
  task stop_pulse;
    @(posedge clk_sys_i);
    stop_exec_i <= 1'b1;
    @(posedge clk_sys_i);
    stop_exec_i <= 1'b0;
    #1;
  endtask
  task t_force;
    do_reset();
    rd("force reads zero", ADDR_DBG_FORCE, 8'h00);
    cpu(ADDR_DBG_FORCE, 1'b1, 8'h01);
    chk("user force", 8'h00, frc);
    dbg(ADDR_DBG_FORCE, 8'h01);
    chk("debug force", 8'h01, frc);
    dbg(ADDR_DBG_FORCE, 8'h00);
    chk("debug zero", 8'h00, frc);
    rd("force after write", ADDR_DBG_FORCE, 8'h00);
  endtask
  task t_opt_one;
    do_reset();
    rd("opt one reset", ADDR_OPT_ONE, 8'hC0);
    stop_pulse();
    chk("stop disallowed", 8'h01, ill);
    // initialisation write taken deliberately
    cpu(ADDR_OPT_ONE, 1'b1, 8'h24);
    chk("timeout sel", 8'h00, opts.watchdog_timeout_sel);
    chk("i2c route", 8'h01, opts.i2c_pin_route);
    chk("stop allow bit", 8'h01, opts.stop_mode_allow);
    cpu(ADDR_OPT_ONE, 1'b1, 8'hFF);
    rd("opt one locked", ADDR_OPT_ONE, 8'h24);
    stop_pulse();
    chk("stop allowed", 8'h01, stp);
    chk("no illegal", 8'h00, ill);
  endtask
  task t_opt_two;
    do_reset();
    rd("opt two reset", ADDR_OPT_TWO, 8'h00);
    cpu(ADDR_OPT_TWO, 1'b1, 8'hDF);
    chk("clock sel", 8'h01, opts.watchdog_clock_sel);
    chk("window on", 8'h01, opts.watchdog_window_mode);
    chk("routes set", 8'h0F, {opts.timer2_ch1_route, opts.timer2_ch0_route,
      opts.timer1_ch1_route, opts.timer1_ch0_route});
    cpu(ADDR_OPT_TWO, 1'b1, 8'h00);
    rd("opt two once bits", ADDR_OPT_TWO, 8'hC0);
    chk("routes clear", 8'h00, {opts.timer2_ch1_route, opts.timer2_ch0_route,
      opts.timer1_ch1_route, opts.timer1_ch0_route});
    do_reset();
    dbg(ADDR_OPT_TWO, 8'h40);
    chk("window needs bus clk", 8'h00, opts.watchdog_window_mode);
    cpu(ADDR_OPT_TWO, 1'b1, 8'hC0);
    chk("debug took lock", 8'h00, opts.watchdog_clock_sel);
  endtask
  task t_key;
    do_reset();
    @(posedge clk_sys_i);
    wdog_window_open_i <= 1'b1;
    cpu(ADDR_RST_STATUS, 1'b1, KEY_FIRST);
    chk("no early refresh", 8'h00, rfr);
    cpu(ADDR_RST_STATUS, 1'b1, KEY_SECOND);
    chk("key refresh", 8'h01, rfr);
    cpu(ADDR_RST_STATUS, 1'b1, KEY_SECOND);
    chk("lone second key", 8'h00, rfr);
    chk("lone key no reset", 8'h00, wrst);
    key_pair();
    chk("back to back keys", 8'h01, rfr);
    cpu(ADDR_RST_STATUS, 1'b1, 8'h12);
    chk("bad key reset", 8'h01, wrst);
    cpu(ADDR_OPT_TWO, 1'b1, 8'hC0);
    @(posedge clk_sys_i);
    wdog_window_open_i <= 1'b0;
    cpu(ADDR_RST_STATUS, 1'b1, KEY_FIRST);
    chk("early write reset", 8'h01, wrst);
  endtask
  // wait out the sync and register stages
  task settle;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task t_capture;
    do_reset();
    cpu(ADDR_OPT_TWO, 1'b1, 8'h10);
    chk("cmp link bit", 8'h01, opts.comparator_to_capture);
    @(posedge clk_sys_i);
    cmp_out_i <= 1'b1;
    settle();
    chk("comparator linked", 8'h01, ch0);
    cpu(ADDR_OPT_TWO, 1'b1, 8'h00);
    settle();
    chk("comparator cut", 8'h00, ch0);
    @(posedge clk_sys_i);
    timer_module_one_ch0_pin_i <= 1'b1;
    settle();
    chk("pin path", 8'h01, ch0);
  endtask
  task give_verdict;
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    {stop_exec_i, wdog_window_open_i, cmp_out_i, timer_module_one_ch0_pin_i, dbg_go} = '0;
    dbg_addr = '0;
    dbg_data = '0;
    cpu_req = '0;
    mismatches = 0;
    total_checks = 0;
    t_force();
    t_opt_one();
    t_opt_two();
    t_key();
    t_capture();
    give_verdict();
  end
  // hang guard, far beyond the hundred-odd cycles needed
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
